//--- common/mrs_cfg.svh
// Constants for the reset sequencer: timing counts, bus offsets and fields.
// Assumes a single 125 MHz system clock and a 32-bit AHB-Lite register bus.
`ifndef MRS_CFG_SVH
`define MRS_CFG_SVH

// Clock rate and reset delay.
`define MRS_CLK_MHZ 125
`define MRS_RESET_DELAY_MS 100
`define MRS_RESET_DELAY_CYC (`MRS_RESET_DELAY_MS * 1000 * `MRS_CLK_MHZ)
`define MRS_CNT_W 24

// Start-up timer lengths in system clock cycles.
`define MRS_START_LONG_CYC 24'h000080
`define MRS_START_SHORT_CYC 24'h000002

// Low supply qualification length in cycles; a plain default.
`define MRS_LVQ_CYC 16

// Register byte offsets.
`define MRS_OFS_CTRL 8'h00
`define MRS_OFS_STATUS 8'h04
`define MRS_OFS_IRQ_STAT 8'h08
`define MRS_OFS_IRQ_MASK 8'h0C

// Control register fields and reset value.
`define MRS_CTRL_LOWV_EN 0
`define MRS_CTRL_THR_LO 1
`define MRS_CTRL_THR_HI 2
`define MRS_CTRL_START_SHORT 3
`define MRS_CTRL_OSC_LO 4
`define MRS_CTRL_OSC_HI 5
`define MRS_CTRL_W 6
`define MRS_CTRL_RST 6'h01

// Interrupt event bits.
`define MRS_EVT_PIN 0
`define MRS_EVT_LOWV 1
`define MRS_EVT_WDT_RUN 2
`define MRS_EVT_WDT_SLEEP 3
`define MRS_EVT_W 4

`endif

//--- common/mrs_pkg.sv
// Types for the reset sequencer.
// Assumes the users write every reference as mrs_pkg::name.
package mrs_pkg;

   // Sequencer states, one-hot.
   typedef enum logic [3:0] {
      ST_HOLD  = 4'h1,
      ST_DELAY = 4'h2,
      ST_START = 4'h4,
      ST_RUN   = 4'h8
   } mrs_state_t;

   // System oscillator sources.
   typedef enum logic [1:0] {
      OSC_FAST_RC = 2'h0,
      OSC_EXT_RC  = 2'h1,
      OSC_FAST_XT = 2'h2,
      OSC_SLOW_XT = 2'h3
   } mrs_osc_t;

endpackage

//--- hw/mrs_persist.sv
// Persistence filter: output rises once the input has been high for CYC+1 cycles.
// Assumes its input is already synchronised to i_clk.
module mrs_persist #(
   parameter int unsigned CYC = 16
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_resetn,
   // Filtered level.
   input wire logic i_level,
   output logic o_qualified
);

   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic qual_reg;
   logic qual_next;

   // Any low cycle restarts the count, so short dips never qualify.
   always_comb begin
      cnt_next = cnt_reg;
      qual_next = 1'b0;
      if (!i_level) begin
         cnt_next = 16'h0000;
      end else if (cnt_reg >= 16'(CYC)) begin
         qual_next = 1'b1;
      end else begin
         cnt_next = cnt_reg + 16'h0001;
      end
   end

   // Registers of the filter.
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         cnt_reg <= 16'h0000;
         qual_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         qual_reg <= qual_next;
      end
   end

   assign o_qualified = qual_reg;

endmodule

//--- hw/mrs_reset_seq.sv
// Reset sequencer of a small microcontroller with an AHB-Lite register slave.
// Assumes a watchdog, core and supply monitor outside; i_resetn is power-on reset.
// Summary of operation
// - Power-on reset clears the program counter so fetch starts at address zero.
// - Power-on reset presets all port data and direction registers to ones.
// - A low reset pin holds the core, and release adds a reset delay of 100 ms.
// - Pulling the reset pin low while running clears the program counter and restarts.
// - A pin reset while running leaves some registers at their previous contents.
// - The low voltage reset is enabled and its threshold chosen by configuration.
// - A low voltage reset is a full reset, the same as a pin reset.
// - A low supply shorter than the qualification time causes no reset.
// - A watchdog time-out while running acts as a pin reset and sets the timeout flag.
// - A watchdog time-out in idle or sleep clears only PC and SP and sets the flag.
// - With an RC clock the start-up timer is selectable as 128 or 2 cycles.
// - With a crystal clock the start-up timer always counts 128 cycles.
// - Power-on clears both flags, pin or low voltage keep them, sleep time-out sets both.
//
// Local design decisions: the AHB-Lite register port and the address map.
`include "mrs_cfg.svh"

module mrs_reset_seq #(
   parameter int unsigned RESET_DELAY_CYC = `MRS_RESET_DELAY_CYC,
   parameter int unsigned LVQ_CYC = `MRS_LVQ_CYC
) (
   // Clock and power-on reset.
   input wire logic i_clk,
   input wire logic i_resetn,
   // Reset sources and core status.
   input wire logic i_ext_reset_pin_n,
   input wire logic i_low_supply,
   input wire logic i_wdt_timeout,
   input wire logic i_sleep_mode,
   input wire logic i_halt_exec,
   input wire logic i_wdt_clear,
   // Reset controls toward the core.
   output logic o_core_hold,
   output logic o_pc_clear,
   output logic o_sp_clear,
   output logic o_reg_init,
   output logic o_port_preset,
   output logic o_wdt_timeout_flag,
   output logic o_powerdown_flag,
   output logic [1:0] o_low_supply_threshold,
   output logic o_irq,
   // AHB-Lite slave.
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp
);

   localparam int CW = `MRS_CNT_W;
   localparam int EW = `MRS_EVT_W;

   // Start-up timer length; power-on always takes the long count.
   function automatic logic [CW-1:0] start_cycles(input logic [1:0] osc, input logic short_sel,
                                                  input logic por);
      logic rc_clock;
      rc_clock = (osc == mrs_pkg::OSC_FAST_RC) || (osc == mrs_pkg::OSC_EXT_RC);
      if (rc_clock && short_sel && !por) begin
         start_cycles = `MRS_START_SHORT_CYC - 24'h000001;
      end else begin
         start_cycles = `MRS_START_LONG_CYC - 24'h000001;
      end
   endfunction

   logic pin_meta_reg;
   logic pin_sync_reg;
   logic low_meta_reg;
   logic low_sync_reg;
   logic lv_qual;
   mrs_pkg::mrs_state_t state_reg;
   mrs_pkg::mrs_state_t state_next;
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic full_reg;
   logic full_next;
   logic por_reg;
   logic por_next;
   logic to_reg;
   logic to_next;
   logic pwrdn_reg;
   logic pwrdn_next;
   logic [EW-1:0] evt;
   logic full_src;
   logic lowv_hit;
   logic hold_reg;
   logic pc_reg;
   logic sp_reg;
   logic init_reg;
   logic preset_reg;
   logic [`MRS_CTRL_W-1:0] ctrl_reg;
   logic [`MRS_CTRL_W-1:0] ctrl_next;
   logic [EW-1:0] istat_reg;
   logic [EW-1:0] istat_next;
   logic [EW-1:0] imask_reg;
   logic [EW-1:0] imask_next;
   logic irq_reg;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic addr_ok;

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
         low_meta_reg <= 1'b0;
         low_sync_reg <= 1'b0;
      end else begin
         pin_meta_reg <= i_ext_reset_pin_n;
         pin_sync_reg <= pin_meta_reg;
         low_meta_reg <= i_low_supply;
         low_sync_reg <= low_meta_reg;
      end
   end

   mrs_persist #(
      .CYC(LVQ_CYC)
   ) u_low_supply_qualify (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_level(low_sync_reg),
      .o_qualified(lv_qual)
   );

   assign lowv_hit = ctrl_reg[`MRS_CTRL_LOWV_EN] & lv_qual;
   assign full_src = ~pin_sync_reg | lowv_hit;

   // Sequencer next state; a full source always returns to the hold state.
   always_comb begin
      state_next = state_reg;
      cnt_next = (cnt_reg != '0) ? cnt_reg - 24'h000001 : cnt_reg;
      full_next = full_reg;
      por_next = por_reg;
      to_next = to_reg;
      pwrdn_next = pwrdn_reg;
      evt = '0;
      if (i_wdt_clear) begin
         to_next = 1'b0;
         pwrdn_next = 1'b0;
      end
      if (i_halt_exec) begin
         pwrdn_next = 1'b1;
      end
      case (state_reg)
         mrs_pkg::ST_HOLD: begin
            if (!full_src) begin
               state_next = mrs_pkg::ST_DELAY;
               cnt_next = CW'(RESET_DELAY_CYC - 1);
            end
         end
         mrs_pkg::ST_DELAY: begin
            if (full_src) begin
               state_next = mrs_pkg::ST_HOLD;
            end else if (cnt_reg == '0) begin
               state_next = mrs_pkg::ST_START;
               cnt_next = start_cycles(ctrl_reg[`MRS_CTRL_OSC_HI:`MRS_CTRL_OSC_LO],
                                       ctrl_reg[`MRS_CTRL_START_SHORT], por_reg);
            end
         end
         mrs_pkg::ST_START: begin
            if (full_src) begin
               state_next = mrs_pkg::ST_HOLD;
               full_next = 1'b1;
            end else if (cnt_reg == '0) begin
               state_next = mrs_pkg::ST_RUN;
               full_next = 1'b0;
               por_next = 1'b0;
            end
         end
         mrs_pkg::ST_RUN: begin
            if (full_src) begin
               state_next = mrs_pkg::ST_HOLD;
               full_next = 1'b1;
               evt[`MRS_EVT_PIN] = ~pin_sync_reg;
               evt[`MRS_EVT_LOWV] = lowv_hit;
            end else if (i_wdt_timeout && !i_sleep_mode) begin
               state_next = mrs_pkg::ST_DELAY;
               cnt_next = CW'(RESET_DELAY_CYC - 1);
               full_next = 1'b1;
               to_next = 1'b1;
               evt[`MRS_EVT_WDT_RUN] = 1'b1;
            end else if (i_wdt_timeout) begin
               state_next = mrs_pkg::ST_START;
               cnt_next = start_cycles(ctrl_reg[`MRS_CTRL_OSC_HI:`MRS_CTRL_OSC_LO],
                                       ctrl_reg[`MRS_CTRL_START_SHORT], 1'b0);
               full_next = 1'b0;
               to_next = 1'b1;
               pwrdn_next = 1'b1;
               evt[`MRS_EVT_WDT_SLEEP] = 1'b1;
            end
         end
         default: begin
            state_next = mrs_pkg::ST_HOLD;
            full_next = 1'b1;
         end
      endcase
   end

   // Sequencer registers; power-on starts held with both flags clear.
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         state_reg <= mrs_pkg::ST_HOLD;
         cnt_reg <= '0;
         full_reg <= 1'b1;
         por_reg <= 1'b1;
         to_reg <= 1'b0;
         pwrdn_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         full_reg <= full_next;
         por_reg <= por_next;
         to_reg <= to_next;
         pwrdn_reg <= pwrdn_next;
      end
   end

   // Core controls are registered from the next state so they track it exactly.
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         hold_reg <= 1'b1;
         pc_reg <= 1'b1;
         sp_reg <= 1'b1;
         init_reg <= 1'b1;
         preset_reg <= 1'b1;
      end else begin
         hold_reg <= (state_next != mrs_pkg::ST_RUN);
         pc_reg <= (state_next != mrs_pkg::ST_RUN);
         sp_reg <= (state_next != mrs_pkg::ST_RUN);
         init_reg <= (state_next != mrs_pkg::ST_RUN) & full_next;
         preset_reg <= (state_next != mrs_pkg::ST_RUN) & por_next;
      end
   end

   // Bus decode of the address-phase address; unmapped offsets read zero.
   assign addr_ok = (i_haddr[7:0] == `MRS_OFS_CTRL) || (i_haddr[7:0] == `MRS_OFS_STATUS) ||
                    (i_haddr[7:0] == `MRS_OFS_IRQ_STAT) || (i_haddr[7:0] == `MRS_OFS_IRQ_MASK);

   // Read data is captured at the address phase, so the slave never waits.
   always_comb begin
      rdata_next = rdata_reg;
      if (i_hsel && i_htrans[1] && i_hready && !i_hwrite) begin
         if (i_haddr[7:0] == `MRS_OFS_CTRL) begin
            rdata_next = {26'h0000000, ctrl_reg};
         end else if (i_haddr[7:0] == `MRS_OFS_STATUS) begin
            rdata_next = {24'h000000, state_reg, 2'h0, pwrdn_reg, to_reg};
         end else if (i_haddr[7:0] == `MRS_OFS_IRQ_STAT) begin
            rdata_next = {28'h0000000, istat_reg};
         end else if (i_haddr[7:0] == `MRS_OFS_IRQ_MASK) begin
            rdata_next = {28'h0000000, imask_reg};
         end else begin
            rdata_next = 32'h00000000;
         end
      end
   end

   // Writes land at the end of the data phase; a new event beats its own clear.
   always_comb begin
      ctrl_next = ctrl_reg;
      imask_next = imask_reg;
      istat_next = istat_reg;
      if (wr_pend_reg) begin
         if (wr_addr_reg == `MRS_OFS_CTRL) begin
            ctrl_next = i_hwdata[`MRS_CTRL_W-1:0];
         end else if (wr_addr_reg == `MRS_OFS_IRQ_STAT) begin
            istat_next = istat_reg & ~i_hwdata[EW-1:0];
         end else if (wr_addr_reg == `MRS_OFS_IRQ_MASK) begin
            imask_next = i_hwdata[EW-1:0];
         end
      end
      istat_next = istat_next | evt;
   end

   // Bus and interrupt registers; the slave always answers OKAY at once.
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         ctrl_reg <= `MRS_CTRL_RST;
         istat_reg <= '0;
         imask_reg <= '0;
         irq_reg <= 1'b0;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         rdata_reg <= 32'h00000000;
      end else begin
         ctrl_reg <= ctrl_next;
         istat_reg <= istat_next;
         imask_reg <= imask_next;
         irq_reg <= |(istat_next & imask_next);
         wr_pend_reg <= i_hsel & i_htrans[1] & i_hready & i_hwrite & addr_ok;
         wr_addr_reg <= i_haddr[7:0];
         rdata_reg <= rdata_next;
      end
   end

   assign o_core_hold = hold_reg;
   assign o_pc_clear = pc_reg;
   assign o_sp_clear = sp_reg;
   assign o_reg_init = init_reg;
   assign o_port_preset = preset_reg;
   assign o_wdt_timeout_flag = to_reg;
   assign o_powerdown_flag = pwrdn_reg;
   assign o_low_supply_threshold = ctrl_reg[`MRS_CTRL_THR_HI:`MRS_CTRL_THR_LO];
   assign o_irq = irq_reg;
   assign o_hrdata = rdata_reg;
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;

   property p_pin_restart;
      @(posedge i_clk) disable iff (!i_resetn)
      (state_reg == mrs_pkg::ST_RUN && !pin_sync_reg)
      |=> (o_pc_clear && o_reg_init && o_core_hold);
   endproperty
   a_pin_restart: assert property (p_pin_restart) else $error("pin reset did not restart");

   property p_sleep_wdt;
      @(posedge i_clk) disable iff (!i_resetn)
      (state_reg == mrs_pkg::ST_RUN && !full_src && i_wdt_timeout && i_sleep_mode)
      |=> (o_sp_clear && !o_reg_init && to_reg && pwrdn_reg && state_reg == mrs_pkg::ST_START);
   endproperty
   a_sleep_wdt: assert property (p_sleep_wdt) else $error("sleep time-out wrong");

   property p_run_wdt;
      @(posedge i_clk) disable iff (!i_resetn)
      (state_reg == mrs_pkg::ST_RUN && !full_src && i_wdt_timeout && !i_sleep_mode)
      |=> (state_reg == mrs_pkg::ST_DELAY && to_reg && o_reg_init);
   endproperty
   a_run_wdt: assert property (p_run_wdt) else $error("run time-out wrong");

   property p_lowv_full;
      @(posedge i_clk) disable iff (!i_resetn)
      (state_reg == mrs_pkg::ST_RUN && lowv_hit)
      |=> (state_reg == mrs_pkg::ST_HOLD && o_reg_init);
   endproperty
   a_lowv_full: assert property (p_lowv_full) else $error("low voltage not full reset");

   property p_lowv_off;
      @(posedge i_clk) disable iff (!i_resetn)
      (state_reg == mrs_pkg::ST_RUN && !ctrl_reg[`MRS_CTRL_LOWV_EN] && pin_sync_reg
       && !i_wdt_timeout) |=> (state_reg == mrs_pkg::ST_RUN);
   endproperty
   a_lowv_off: assert property (p_lowv_off) else $error("disabled low voltage reset acted");

   property p_delay_load;
      @(posedge i_clk) disable iff (!i_resetn)
      (state_reg == mrs_pkg::ST_HOLD && !full_src)
      |=> (state_reg == mrs_pkg::ST_DELAY && cnt_reg == CW'(RESET_DELAY_CYC - 1) && o_core_hold);
   endproperty
   a_delay_load: assert property (p_delay_load) else $error("reset delay not loaded");

   property p_crystal_start;
      @(posedge i_clk) disable iff (!i_resetn)
      (state_reg == mrs_pkg::ST_DELAY && cnt_reg == '0 && !full_src
       && ctrl_reg[`MRS_CTRL_OSC_HI])
      |=> (state_reg == mrs_pkg::ST_START && cnt_reg == `MRS_START_LONG_CYC - 24'h000001);
   endproperty
   a_crystal_start: assert property (p_crystal_start) else $error("crystal timer not 128");

   property p_short_start;
      @(posedge i_clk) disable iff (!i_resetn)
      (state_reg == mrs_pkg::ST_RUN && !full_src && i_wdt_timeout && i_sleep_mode
       && !ctrl_reg[`MRS_CTRL_OSC_HI] && ctrl_reg[`MRS_CTRL_START_SHORT])
      |=> (cnt_reg == `MRS_START_SHORT_CYC - 24'h000001) ##2 (state_reg == mrs_pkg::ST_RUN);
   endproperty
   a_short_start: assert property (p_short_start) else $error("short timer not 2");

   property p_dip;
      @(posedge i_clk) disable iff (!i_resetn)
      $rose(low_sync_reg) |-> !lv_qual ##1 !lv_qual;
   endproperty
   a_dip: assert property (p_dip) else $error("low supply qualified too soon");

   property p_flags_keep;
      @(posedge i_clk) disable iff (!i_resetn)
      (state_reg == mrs_pkg::ST_RUN && !pin_sync_reg && !i_halt_exec && !i_wdt_clear)
      |=> ($stable(to_reg) && $stable(pwrdn_reg));
   endproperty
   a_flags_keep: assert property (p_flags_keep) else $error("pin reset changed flags");

   property p_preset;
      @(posedge i_clk) disable iff (!i_resetn)
      o_port_preset |-> (o_reg_init && o_pc_clear && o_core_hold);
   endproperty
   a_preset: assert property (p_preset) else $error("port preset outside full reset");

   property p_irq;
      @(posedge i_clk) disable iff (!i_resetn)
      o_irq == |(istat_reg & imask_reg);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt level wrong");

endmodule

//--- dv/mrs_far_side.sv
// Far-side model: the reset switch with its pull-up, and the supply monitor.
// Assumes commands come from the bench by non-blocking assignment at a rising edge.
module mrs_far_side (
   // Clock and commands.
   input wire logic i_clk,
   input wire logic i_press,
   input wire logic i_dip,
   input wire logic [7:0] i_len,
   // Lines toward the sequencer.
   output logic o_ext_reset_pin_n,
   output logic o_low_supply
);
   timeunit 1ns;
   timeprecision 1ps;
   int pin_cnt = 0;
   int dip_cnt = 0;

   // The switch holds the pin low for the asked length; the pull-up then returns it high.
   // A dip lasts exactly the asked length, so a short one tests the qualification filter.
   always @(posedge i_clk) begin
      if (i_press) begin
         pin_cnt <= i_len;
      end else if (pin_cnt > 0) begin
         pin_cnt <= pin_cnt - 1;
      end
      if (i_dip) begin
         dip_cnt <= i_len;
      end else if (dip_cnt > 0) begin
         dip_cnt <= dip_cnt - 1;
      end
   end

   // Pin idles high through its pull-up.
   assign o_ext_reset_pin_n = (pin_cnt == 0);
   assign o_low_supply = (dip_cnt != 0);
endmodule

//--- dv/mrs_reset_seq_tb.sv
// Self-checking bench for the reset sequencer, its sources and its register bus.
// Assumes one 125 MHz clock; the reset delay is shortened to keep the run brief.
`include "mrs_cfg.svh"

module mrs_reset_seq_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned DLY = 20;
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic i_wdt_timeout = 1'b0;
   logic i_sleep_mode = 1'b0;
   logic i_halt_exec = 1'b0;
   logic i_wdt_clear = 1'b0;
   logic press = 1'b0;
   logic dip = 1'b0;
   logic [7:0] len = 8'h00;
   logic i_hsel = 1'b0;
   logic [31:0] i_haddr = 32'h0;
   logic [1:0] i_htrans = 2'h0;
   logic i_hwrite = 1'b0;
   logic [2:0] i_hsize = 3'h2;
   logic [31:0] i_hwdata = 32'h0;
   logic pin_n, low_sup, hold, pc_clr, sp_clr, reg_init, port_pre, to_f, pd_f, irq;
   logic hready, hresp;
   logic [1:0] thr;
   logic [31:0] hrdata;
   int miscompares = 0;
   int total_checks = 0;
   int seed = 32'h7EDAF22B;
   int n;
   logic rd_pend = 1'b0;
   logic [31:0] exp_q[$];
   logic [3:0] snap;
   logic [31:0] d;

   mrs_far_side far (.i_clk(i_clk), .i_press(press), .i_dip(dip), .i_len(len),
      .o_ext_reset_pin_n(pin_n), .o_low_supply(low_sup));

   mrs_reset_seq #(.RESET_DELAY_CYC(DLY), .LVQ_CYC(4)) dut (.i_clk(i_clk),
      .i_resetn(i_resetn), .i_ext_reset_pin_n(pin_n), .i_low_supply(low_sup),
      .i_wdt_timeout(i_wdt_timeout), .i_sleep_mode(i_sleep_mode),
      .i_halt_exec(i_halt_exec), .i_wdt_clear(i_wdt_clear), .o_core_hold(hold),
      .o_pc_clear(pc_clr), .o_sp_clear(sp_clr), .o_reg_init(reg_init),
      .o_port_preset(port_pre), .o_wdt_timeout_flag(to_f), .o_powerdown_flag(pd_f),
      .o_low_supply_threshold(thr), .o_irq(irq), .i_hsel(i_hsel), .i_haddr(i_haddr),
      .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
      .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp));

   // Free-running system clock.
   initial begin
      forever #4 i_clk = ~i_clk;
   end

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Waits are bounded so a stuck bus ends as a counted mismatch, not a hang.
   task automatic wait_rdy();
      int k;
      k = 0;
      do begin
         @(posedge i_clk);
         k++;
      end while (hready !== 1'b1 && k < 50);
      if (k >= 50) begin
         miscompares++;
         wrap_up();
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] dat);
      i_hsel <= 1'b1;
      i_haddr <= {24'h0, a};
      i_htrans <= 2'h2;
      i_hwrite <= wr;
      i_hsize <= 3'h2;
      wait_rdy();
      i_htrans <= 2'h0;
      i_hwdata <= dat;
      wait_rdy();
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask

   // Counts the cycles that the core is held, with a snapshot of the clear lines.
   task automatic measure();
      int k;
      k = 0;
      n = 0;
      while (hold !== 1'b1 && k < 60) begin
         @(posedge i_clk);
         k++;
      end
      snap = {pc_clr, sp_clr, reg_init, port_pre};
      while (hold === 1'b1 && n < 2000) begin
         @(posedge i_clk);
         n++;
      end
      if (k >= 60 || n >= 2000) begin
         miscompares++;
         wrap_up();
      end
   endtask

   task automatic rng(input string nm, input int lo, input int hi);
      check(nm, {31'h0, n >= lo && n <= hi}, 32'h1);
   endtask

   task automatic quiet();
      logic bad;
      bad = 1'b0;
      repeat (40) begin
         @(posedge i_clk);
         if (hold !== 1'b0) bad = 1'b1;
      end
      check("no reset", {31'h0, bad}, 32'h0);
   endtask

   task automatic src(input logic is_dip, input logic [7:0] l);
      press <= !is_dip;
      dip <= is_dip;
      len <= l;
      @(posedge i_clk);
      press <= 1'b0;
      dip <= 1'b0;
   endtask

   task automatic wdt(input logic slp);
      i_sleep_mode <= slp;
      i_wdt_timeout <= 1'b1;
      @(posedge i_clk);
      i_wdt_timeout <= 1'b0;
      i_sleep_mode <= 1'b0;
   endtask

   task automatic irq_is(input logic e);
      repeat (3) @(posedge i_clk);
      check("irq", {31'h0, irq}, {31'h0, e});
   endtask

   // Read data stand in the data phase; the oldest note is compared there.
   always @(posedge i_clk) begin
      if (rd_pend) begin
         check("hrdata", hrdata, exp_q.pop_front());
         check("hresp", {31'h0, hresp}, 32'h0);
      end
      rd_pend <= i_hsel && i_htrans[1] && !i_hwrite && hready;
   end

   // Main sequence.
   initial begin
      repeat (20) @(posedge i_clk);
      i_resetn <= 1'b1;
      measure();
      rng("por length", DLY + 128, DLY + 136);
      check("por clears", {28'h0, snap}, 32'hF);
      rd(`MRS_OFS_STATUS, 32'h80);
      rd(`MRS_OFS_CTRL, 32'h01);
      rd(`MRS_OFS_IRQ_MASK, 32'h0);
      bus(1'b1, `MRS_OFS_IRQ_MASK, 32'hF);
      src(1'b0, 8'h0A);
      measure();
      rng("pin length", DLY + 138, DLY + 146);
      check("pin clears", {28'h0, snap}, 32'hE);
      rd(`MRS_OFS_STATUS, 32'h80);
      rd(`MRS_OFS_IRQ_STAT, 32'h1);
      irq_is(1'b1);
      bus(1'b1, `MRS_OFS_IRQ_STAT, 32'h1);
      irq_is(1'b0);
      wdt(1'b0);
      measure();
      rng("wdt run length", DLY + 128, DLY + 130);
      check("wdt run clears", {28'h0, snap}, 32'hE);
      rd(`MRS_OFS_STATUS, 32'h81);
      rd(`MRS_OFS_IRQ_STAT, 32'h4);
      bus(1'b1, `MRS_OFS_IRQ_MASK, 32'hB);
      irq_is(1'b0);
      bus(1'b1, `MRS_OFS_IRQ_MASK, 32'hF);
      irq_is(1'b1);
      bus(1'b1, `MRS_OFS_IRQ_STAT, 32'hF);
      irq_is(1'b0);
      bus(1'b1, `MRS_OFS_CTRL, 32'h05);
      @(posedge i_clk);
      check("threshold", {30'h0, thr}, 32'h2);
      src(1'b1, 8'h02);
      quiet();
      src(1'b1, 8'h10);
      measure();
      check("lvr clears", {28'h0, snap}, 32'hE);
      rd(`MRS_OFS_STATUS, 32'h81);
      bus(1'b1, `MRS_OFS_CTRL, 32'h04);
      src(1'b1, 8'h10);
      quiet();
      // Every oscillator with both timer lengths; only RC sources may shorten it.
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, `MRS_OFS_CTRL, {26'h0, i[1:0], i[2], 3'h0});
         wdt(1'b1);
         measure();
         check("startup", n, (i[2] && i[1:0] < 2) ? 32'h2 : 32'h80);
         check("sleep clears", {28'h0, snap}, 32'hC);
      end
      rd(`MRS_OFS_STATUS, 32'h83);
      i_wdt_clear <= 1'b1;
      @(posedge i_clk);
      i_wdt_clear <= 1'b0;
      rd(`MRS_OFS_STATUS, 32'h80);
      i_halt_exec <= 1'b1;
      @(posedge i_clk);
      i_halt_exec <= 1'b0;
      rd(`MRS_OFS_STATUS, 32'h82);
      bus(1'b1, `MRS_OFS_STATUS, 32'hFF);
      rd(`MRS_OFS_STATUS, 32'h82);
      rd(8'h10, 32'h0);
      // Random mask words; only the four event bits may stick.
      repeat (4) begin
         d = $random(seed);
         bus(1'b1, `MRS_OFS_IRQ_MASK, d);
         rd(`MRS_OFS_IRQ_MASK, d & 32'hF);
      end
      repeat (5) @(posedge i_clk);
      wrap_up();
   end

   // Cuts a hung run short.
   initial begin
      #(8 * 60000);
      miscompares++;
      wrap_up();
   end
endmodule
